//--- include/acp_pkg.sv
package acp_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int NUM_CH  = 16;
  localparam int CH_W    = 4;
  localparam int PAIR_W  = 3;
  localparam int NUM_PR  = NUM_CH / 2;
  localparam int RES_W   = 10;
  localparam int SUB_W   = 2;
  localparam int SH_W    = RES_W + SUB_W;
  localparam int FIFO_AW = 4;
  localparam int CNT_W   = FIFO_AW + 1;

  // ---------------------------------------------------------------
  // command byte fields
  // ---------------------------------------------------------------
  localparam int CMD_CONV_BIT  = 7;
  localparam int CMD_CH_MSB    = 6;
  localparam int CMD_CH_LSB    = 3;
  localparam int CMD_TEMP_BIT  = 0;
  localparam int SET_TAG_MSB   = 7;
  localparam int SET_TAG_LSB   = 6;
  localparam int SET_MODE_MSB  = 5;
  localparam int SET_MODE_LSB  = 4;
  localparam int SET_REF_BIT   = 2;
  localparam int SET_SEL_MSB   = 1;
  localparam int SET_SEL_LSB   = 0;
  localparam logic [1:0] SET_TAG = 2'h1;
  localparam logic [1:0] SEL_UNI = 2'h1;
  localparam logic [1:0] SEL_BIP = 2'h2;

  // ---------------------------------------------------------------
  // clock modes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_PIN_SCAN = 2'h0;
  localparam logic [1:0] MODE_PIN_EACH = 2'h1;
  localparam logic [1:0] MODE_SERIAL   = 2'h2;
  localparam logic [1:0] MODE_EXT_CLK  = 2'h3;
  localparam logic [1:0] MODE_RST      = MODE_SERIAL;
  localparam logic [NUM_PR-1:0] PAIR_RST = 8'h00;

  // ---------------------------------------------------------------
  // serial word positions (16 bits per result)
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_SNAP  = 4'h3;
  localparam logic [3:0] IDX_DATA  = 4'h4;
  localparam logic [3:0] IDX_LAST  = 4'hF;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [1:0] LOAD_WAIT = 2'h2;

  typedef enum logic [1:0] {
    ACP_IDLE = 2'h0,
    ACP_BUSY = 2'h1,
    ACP_DONE = 2'h3
  } acp_conv_st_t;

endpackage

//--- src/acp_fifo_mem.sv
`timescale 1ns/100ps
module acp_fifo_mem
  import acp_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_we,
  input  wire logic [FIFO_AW-1:0] i_waddr,
  input  wire logic [RES_W-1:0]   i_wdata,
  input  wire logic [FIFO_AW-1:0] i_raddr,
  output logic      [RES_W-1:0]   o_rdata
);

  logic [RES_W-1:0] mem_reg [2**FIFO_AW];

  // read-before-write: a write to the read slot shows next cycle
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_reg[i_raddr];
  end

endmodule

//--- src/acp_serial_ctrl.sv
`timescale 1ns/100ps
// Function
// - input bits taken on rising serial clock
// - output bits change on falling serial clock
// - chip select high parks output undriven
// - end-of-conversion low only with valid result
// - shared pin: start input or top channel
// - shared pin: negative reference or channel
// - serial clock moves data; setup picks mode
// - each conversion yields ten result bits
// - channel selection sized to channel count
// - single-ended unipolar; differential either range
// - command byte first, MSB first; second byte
// - setup bits five:four pick clock mode
// - end-of-conversion rises on select or start
// - result word: four zeros, ten, two
module acp_serial_ctrl
  import acp_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_sclk,
  input  wire logic             i_cs_n,
  input  wire logic             i_din,
  input  wire logic             i_convert_request_n,
  input  wire logic             i_conv_done,
  input  wire logic [RES_W-1:0] i_conv_result,
  output logic                  o_dout,
  output logic                  o_dout_oe_n,
  output logic                  o_eoc_n,
  output logic                  o_conv_start,
  output logic      [CH_W-1:0]  o_conv_channel,
  output logic                  o_conv_diff,
  output logic                  o_conv_bipolar,
  output logic                  o_conv_temp,
  output logic                  o_ref_neg_ext,
  output logic                  o_convert_request_n_pin_en
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]         cs_sync;
    logic [2:0]         cnv_sync;
    logic [1:0]         cmd_sync;
    logic               cmd_seen;
    logic [1:0]         pop_sync;
    logic               pop_seen;
    logic [1:0]         mode;
    logic               ref_ext;
    logic               pin_en;
    logic [1:0]         sel_pend;
    logic [NUM_PR-1:0]  uni;
    logic [NUM_PR-1:0]  bip;
    acp_conv_st_t       st;
    logic               start;
    logic [CH_W-1:0]    ch;
    logic               diff;
    logic               bipol;
    logic               temp;
    logic               eoc_n;
    logic               oe_n;
    logic [FIFO_AW-1:0] wr_ptr;
    logic [FIFO_AW-1:0] rd_ptr;
    logic [CNT_W-1:0]   count;
    logic [1:0]         load_cnt;
    logic [RES_W-1:0]   head;
    logic               head_vld;
  } acp_clk_st_t;

  typedef struct packed {
    logic [3:0]      cnt;
    logic [1:0]      nbyte;
    logic [6:0]      in_sh;
    logic [SH_W-1:0] sh;
    logic            snap_vld;
  } acp_lnk_st_t;

  acp_clk_st_t s_reg;
  acp_clk_st_t s_next;
  acp_lnk_st_t l_reg;
  acp_lnk_st_t l_next;

  // link-side crossing registers, never reset: the clock side
  // adopts their value as its reference while in reset; the
  // toggles need a known start or no event is ever seen
  logic       cmd_tgl_reg = 1'b0;
  logic [7:0] cmd_byte_reg;
  logic       cmd_second_reg;
  logic       pop_tgl_reg = 1'b0;
  logic       dout_reg;

  logic [RES_W-1:0] mem_rdata;
  logic             mem_we;

  // ---------------------------------------------------------------
  // channel legality
  // ---------------------------------------------------------------
  function automatic logic ch_ok(input logic [CH_W-1:0] ch,
                                 input logic            pin_en,
                                 input logic            ref_ext);
    logic ok;
    ok = (32'(ch) < NUM_CH);
    if (pin_en && (32'(ch) == NUM_CH - 1)) begin
      ok = 1'b0;
    end
    if (ref_ext && (32'(ch) == NUM_CH - 2)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // ---------------------------------------------------------------
  // link domain: cs high holds the counter cleared
  // ---------------------------------------------------------------
  always_comb begin
    l_next       = l_reg;
    l_next.in_sh = {l_reg.in_sh[5:0], i_din};
    l_next.cnt   = l_reg.cnt + 4'h1;
    if (l_reg.cnt[2:0] == BIT_LAST && l_reg.nbyte != 2'h3) begin
      l_next.nbyte = l_reg.nbyte + 2'h1;
    end
    // leading zeros give four bit times for the head to settle
    if (l_reg.cnt == IDX_SNAP) begin
      l_next.sh       = s_reg.head_vld ? {s_reg.head, {SUB_W{1'b0}}}
                                       : '0;
      l_next.snap_vld = s_reg.head_vld;
    end
  end

  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  always_ff @(posedge i_sclk) begin
    if (!i_cs_n && l_reg.cnt[2:0] == BIT_LAST) begin
      cmd_byte_reg   <= {l_reg.in_sh, i_din};
      cmd_second_reg <= (l_reg.nbyte == 2'h1);
      cmd_tgl_reg    <= ~cmd_tgl_reg;
    end
    if (!i_cs_n && l_reg.cnt == IDX_LAST && l_reg.snap_vld) begin
      pop_tgl_reg <= ~pop_tgl_reg;
    end
  end

  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      dout_reg <= 1'b0;
    end else if (l_reg.cnt >= IDX_DATA) begin
      dout_reg <= l_reg.sh[IDX_LAST - l_reg.cnt];
    end else begin
      dout_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // system clock domain
  // ---------------------------------------------------------------
  always_comb begin
    logic       cs_fall;
    logic       cnv_fall;
    logic       cmd_evt;
    logic       pop_evt;
    logic       trig;
    logic       full;
    logic [7:0] b;
    logic [PAIR_W-1:0] pr;
    s_next   = s_reg;
    s_next.cs_sync  = {s_reg.cs_sync[1:0], i_cs_n};
    s_next.cnv_sync = {s_reg.cnv_sync[1:0], i_convert_request_n};
    s_next.cmd_sync = {s_reg.cmd_sync[0], cmd_tgl_reg};
    s_next.pop_sync = {s_reg.pop_sync[0], pop_tgl_reg};
    s_next.cmd_seen = s_reg.cmd_sync[1];
    s_next.pop_seen = s_reg.pop_sync[1];
    cs_fall  = s_reg.cs_sync[2] && !s_reg.cs_sync[1];
    cnv_fall = s_reg.cnv_sync[2] && !s_reg.cnv_sync[1]
               && o_convert_request_n_pin_en;
    cmd_evt  = s_reg.cmd_sync[1] != s_reg.cmd_seen;
    pop_evt  = s_reg.pop_sync[1] != s_reg.pop_seen;
    b        = cmd_byte_reg;
    trig     = 1'b0;
    s_next.start = 1'b0;
    s_next.oe_n  = s_reg.cs_sync[1];

    // command decode
    if (cmd_evt) begin
      if (cmd_second_reg && s_reg.sel_pend != 2'h0) begin
        if (s_reg.sel_pend == SEL_UNI) begin
          s_next.uni = b;
        end else begin
          s_next.bip = b;
        end
        s_next.sel_pend = 2'h0;
      end else if (!cmd_second_reg && b[CMD_CONV_BIT]) begin
        s_next.ch   = b[CMD_CH_MSB:CMD_CH_LSB];
        s_next.temp = b[CMD_TEMP_BIT];
        // pin-started modes only store the channel and temp bit
        trig = (s_reg.mode == MODE_SERIAL)
               || (s_reg.mode == MODE_EXT_CLK);
      end else if (!cmd_second_reg
                   && b[SET_TAG_MSB:SET_TAG_LSB] == SET_TAG) begin
        s_next.mode     = b[SET_MODE_MSB:SET_MODE_LSB];
        s_next.ref_ext  = b[SET_REF_BIT];
        s_next.sel_pend = b[SET_SEL_MSB:SET_SEL_LSB];
      end
    end
    if (cnv_fall) begin
      trig = 1'b1;
    end

    // conversion sequencing
    pr = s_next.ch[CH_W-1:1];
    unique case (s_reg.st)
      ACP_IDLE, ACP_DONE: begin
        if (cs_fall || cnv_fall) begin
          s_next.eoc_n = 1'b1;
          s_next.st    = ACP_IDLE;
        end
        if (trig && (s_next.temp
                     || ch_ok(s_next.ch, o_convert_request_n_pin_en,
                              s_next.ref_ext))) begin
          s_next.start = 1'b1;
          s_next.diff  = !s_next.temp && (s_next.uni[pr]
                                          || s_next.bip[pr]);
          s_next.bipol = s_next.diff && s_next.bip[pr];
          s_next.st    = ACP_BUSY;
        end
      end
      ACP_BUSY: begin
        if (cs_fall || cnv_fall) begin
          s_next.eoc_n = 1'b1;
        end
        if (i_conv_done) begin
          s_next.st    = ACP_DONE;
          s_next.eoc_n = 1'b0;
        end
      end
    endcase
    if (s_next.mode == MODE_EXT_CLK) begin
      s_next.eoc_n = 1'b1;
    end
    s_next.pin_en = (s_next.mode == MODE_PIN_SCAN)
                    || (s_next.mode == MODE_PIN_EACH);

    // result store: full store drops the oldest
    full = s_reg.count == CNT_W'(2**FIFO_AW);
    if (mem_we) begin
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (pop_evt && s_reg.count != '0) begin
      s_next.rd_ptr   = s_reg.rd_ptr + 1'b1;
      s_next.load_cnt = LOAD_WAIT;
      if (!mem_we) begin
        s_next.count = s_reg.count - 1'b1;
      end
    end else if (mem_we) begin
      if (full) begin
        s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
      end else begin
        s_next.count = s_reg.count + 1'b1;
      end
    end
    if (s_reg.load_cnt != 2'h0) begin
      s_next.load_cnt = s_reg.load_cnt - 2'h1;
    end
    // head only moves while deselected or right after a pop,
    // so the link side never samples it mid-change
    if (s_reg.cs_sync[2] || s_reg.load_cnt == 2'h1) begin
      s_next.head     = mem_rdata;
      s_next.head_vld = s_reg.count != '0;
    end

    if (i_srst) begin
      s_next          = '0;
      s_next.cs_sync  = 3'h7;
      s_next.cnv_sync = 3'h7;
      s_next.cmd_sync = {2{cmd_tgl_reg}};
      s_next.cmd_seen = cmd_tgl_reg;
      s_next.pop_sync = {2{pop_tgl_reg}};
      s_next.pop_seen = pop_tgl_reg;
      s_next.mode     = MODE_RST;
      s_next.uni      = PAIR_RST;
      s_next.bip      = PAIR_RST;
      s_next.st       = ACP_IDLE;
      s_next.eoc_n    = 1'b1;
      s_next.oe_n     = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    s_reg <= s_next;
  end

  assign mem_we = (s_reg.st == ACP_BUSY) && i_conv_done;

  acp_fifo_mem u_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (s_reg.wr_ptr),
    .i_wdata (i_conv_result),
    .i_raddr (s_next.rd_ptr),
    .o_rdata (mem_rdata)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_dout         = dout_reg;
  assign o_dout_oe_n    = s_reg.oe_n;
  assign o_eoc_n        = s_reg.eoc_n;
  assign o_conv_start   = s_reg.start;
  assign o_conv_channel = s_reg.ch;
  assign o_conv_diff    = s_reg.diff;
  assign o_conv_bipolar = s_reg.bipol;
  assign o_conv_temp    = s_reg.temp;
  assign o_ref_neg_ext  = s_reg.ref_ext;
  assign o_convert_request_n_pin_en = s_reg.pin_en;

endmodule

//--- tb/acp_serial_chk.sv
`timescale 1ns/100ps
module acp_serial_chk (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_cs_n,
  input  wire logic i_convert_request_n,
  input  wire logic i_conv_done,
  input  wire logic o_dout,
  input  wire logic o_dout_oe_n,
  input  wire logic o_eoc_n,
  input  wire logic o_conv_start,
  input  wire logic o_ref_neg_ext,
  input  wire logic o_convert_request_n_pin_en
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  // a done pulse may set the flag again, so demand a quiet front end
  sequence quiet_front;
    (!i_conv_done)[*6];
  endsequence

  AST_EOC_CS: assert property ($fell(i_cs_n) ##0 quiet_front |-> o_eoc_n)
    else $error("end flag still low after select fell");
  AST_EOC_PIN: assert property (($fell(i_convert_request_n) && o_convert_request_n_pin_en)
    ##0 quiet_front |-> o_eoc_n)
    else $error("end flag still low after start pin fell");
  AST_EOC_DONE: assert property ($fell(o_eoc_n) |-> $past(i_conv_done))
    else $error("end flag fell without a finished conversion");
  AST_OE_HI: assert property (i_cs_n[*4] |-> o_dout_oe_n)
    else $error("output driven while deselected");
  AST_OE_LO: assert property ((!i_cs_n)[*4] |-> !o_dout_oe_n)
    else $error("output not driven while selected");
  AST_DOUT_ZERO: assert property (i_cs_n[*2] |-> !o_dout)
    else $error("serial output not parked low");
  AST_START_ONE: assert property (o_conv_start |=> !o_conv_start)
    else $error("start pulse longer than one cycle");
  AST_CFG_HOLD: assert property (i_cs_n[*8] |=>
    $stable({o_ref_neg_ext, o_convert_request_n_pin_en}))
    else $error("setup changed while deselected");
endmodule

//--- tb/acp_host_model.sv
`timescale 1ns/100ps
// host master; its clock idles low and stands still between frames
module acp_host_model (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_din,
  input  wire logic i_dout,
  input  wire logic i_dout_oe_n
);
  initial begin
    o_sclk = 1'h0;
    o_cs_n = 1'h1;
    o_din = 1'h0;
  end

  task automatic xfer(input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    rx = 32'h0;
    o_cs_n = 1'h0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      o_din = tx[i];
      #62.5 o_sclk = 1'h1;
      // an undriven line reads back inverted, never as a lucky match
      rx = {rx[30:0], i_dout_oe_n ? ~i_dout : i_dout};
      #62.5 o_sclk = 1'h0;
    end
    #60 o_cs_n = 1'h1;
    o_din = ~o_din;
    #100;
  endtask
endmodule

//--- tb/adc_serial_control_port_tb_top.sv
`timescale 1ns/100ps
module adc_serial_control_port_tb_top;
  import acp_pkg::*;
  logic             i_clk, i_srst, sclk, cs_n, din, req_n, done;
  logic             dout, oe_n, eoc_n, start, diff, bip, temp;
  logic             ref_ext, pin_en, r;
  logic [RES_W-1:0] res;
  logic [CH_W-1:0]  ch, c;
  logic [31:0]      rx;
  logic [15:0]      q[$];
  logic [7:0]       um, bm, st;
  int               bad_count, n_compared, cyc, cd, starts, n0;

  always #12.5 i_clk = ~i_clk;

  acp_serial_ctrl uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_din(din), .i_convert_request_n(req_n), .i_conv_done(done),
    .i_conv_result(res), .o_dout(dout), .o_dout_oe_n(oe_n),
    .o_eoc_n(eoc_n), .o_conv_start(start), .o_conv_channel(ch),
    .o_conv_diff(diff), .o_conv_bipolar(bip), .o_conv_temp(temp),
    .o_ref_neg_ext(ref_ext), .o_convert_request_n_pin_en(pin_en)
  );

  acp_host_model u_host (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout),
    .i_dout_oe_n(oe_n)
  );

  // ---------------------------------------------------------------
  // front end model: finishes each started conversion 5 cycles later
  // ---------------------------------------------------------------
  always @(negedge i_clk) begin
    cyc++;
    done = 1'h0;
    if (cd == 1) begin
      res = RES_W'($urandom);
      done = 1'h1;
      q.push_back({4'h0, res, 2'h0});
    end
    if (cd > 0) cd--;
    if (start === 1'h1) begin
      cd = 5;
      starts++;
      st = {1'h0, ch, diff, bip, temp};
    end
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [15:0] v, input int n);
    u_host.xfer(n, {16'h0, v}, rx);
    repeat (8) @(negedge i_clk);
  endtask

  task automatic rd(input bit wait_eoc);
    logic [15:0] e;
    int          k;
    k = 0;
    while (wait_eoc && eoc_n !== 1'h0 && k < 200) begin
      @(negedge i_clk);
      k++;
    end
    if (wait_eoc) chk_cfg({7'h0, eoc_n}, 8'h00);
    e = (q.size() > 0) ? q.pop_front() : 16'h0;
    u_host.xfer(16, 32'h0, rx);
    chk_word(rx[15:0], e);
    repeat (4) @(negedge i_clk);
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    i_clk = 1'h0;
    i_srst = 1'h1;
    req_n = 1'h1;
    done = 1'h0;
    res = 10'h000;
    {cd, cyc, bad_count, n_compared, starts} = '0;
    st = 8'h00;
    void'($urandom(36));
    repeat (16) @(negedge i_clk);
    i_srst = 1'h0;
    @(negedge i_clk);
    chk_cfg({4'h0, eoc_n, oe_n, start, pin_en}, 8'h0C);
    rd(0);
    for (int m = 0; m < 4; m++) begin
      r = 1'($urandom);
      send({8'h0, 2'h1, 2'(m), 1'h0, r, 2'h0}, 8);
      chk_cfg({6'h0, pin_en, ref_ext}, {6'h0, m < 2, r});
    end
    // mode 11 still converts but keeps the end flag high
    n0 = starts;
    send({8'h0, 1'h1, 4'h3, 3'h0}, 8);
    repeat (12) @(negedge i_clk);
    chk_cfg({6'h0, eoc_n, starts == n0 + 1}, 8'h03);
    rd(0);
    um = 8'($urandom);
    bm = 8'($urandom) & ~um;
    send({8'h61, um}, 16);
    send({8'h62, bm}, 16);
    for (int i = 0; i < 8; i++) begin
      c = 4'($urandom);
      n0 = starts;
      send({8'h0, 1'h1, c, 2'h0, i == 7}, 8);
      chk_cfg(8'(starts - n0), 8'h01);
      if (i == 7) chk_cfg({7'h0, st[0]}, 8'h01);
      else chk_cfg(st, {1'h0, c, um[c[3:1]] | bm[c[3:1]], bm[c[3:1]], 1'h0});
      rd(1);
    end
    // start pin mode: a serial command only stores its channel and temp bit
    send({8'h0, 8'h50}, 8);
    // top channel belongs to the start pin: refused
    n0 = starts;
    send({8'h0, 8'hF8}, 8);
    req_n = 1'h0;
    repeat (10) @(negedge i_clk);
    req_n = 1'h1;
    repeat (12) @(negedge i_clk);
    chk_cfg(8'(starts - n0), 8'h00);
    n0 = starts;
    send({8'h0, 8'hA8}, 8);
    chk_cfg(8'(starts - n0), 8'h00);
    req_n = 1'h0;
    repeat (10) @(negedge i_clk);
    req_n = 1'h1;
    chk_cfg(8'(starts - n0), 8'h01);
    rd(1);
    report_and_stop();
  end
endmodule

bind acp_serial_ctrl acp_serial_chk u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n),
  .i_convert_request_n(i_convert_request_n), .i_conv_done(i_conv_done),
  .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n), .o_eoc_n(o_eoc_n),
  .o_conv_start(o_conv_start), .o_ref_neg_ext(o_ref_neg_ext),
  .o_convert_request_n_pin_en(o_convert_request_n_pin_en)
);
